// File: rtl/sio_socket_out.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sio_cfg.svh"
// Overview of operation
// [RULE1] Empty socket keeps isolation asserted
// [RULE2] Isolate from shutdown done to bring-up done
// [RULE3] Skipped steps still mark isolation points
// [RULE4] Isolation low at all other times
// [RULE5] Core reset leaves isolation unchanged
// [RULE6] Bring-up after core reset keeps isolation low
// [RULE7] Shutdown holds, then follows written isolation
// [RULE8] Restart sets isolation from fill state
// [RULE9] Per-module reset enable, polarity, duration
// [RULE10] Reset pulses right after load if enabled
// [RULE11] Core reset pulses reset unless bring-up skipped
// [RULE12] Shutdown state reset follows written value
// [RULE13] Bring-up finishes before reset asserts
// [RULE14] Reset otherwise inactive, core reset untouched
// [RULE15] Reset rises cycle after isolation falls
// [RULE16] Power-on reset level from build polarity
// [RULE17] Build polarity kept until settings fetched
// [RULE18] Bring-up request waits for proceed, unbounded
// [RULE19] Both outputs are registered, glitch free
module sio_socket_out
  import sio_pkg::*;
#(
  parameter int        NUM_MOD  = 128,          // Loadable modules
  parameter bit        POR_FULL = 1'b1,         // Socket full at power-on
  parameter bit [6:0]  POR_ID   = 7'h00,        // Module present at power-on
  parameter bit [10:0] POR_MCFG = `SIO_POR_MCFG // Build-time settings
)(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire sio_apb_s    apb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire sio_seq_s    seq,
  output logic             module_isolate,
  output logic             module_reset_out,
  output logic             software_bringup_request,
  output logic             irq
);

  localparam sio_mcfg_s POR_CFG = sio_mcfg_s'(POR_MCFG);

  sio_state_e      state;            // Current manager state
  sio_state_e      next_state;       // State after this edge
  logic [2:0]      fetch_cnt;        // Settings fetch delay
  logic [7:0]      dur_cnt;          // Reset pulse length left
  logic            full;             // Socket holds a module
  logic [6:0]      cur_id;           // Module in the socket
  logic [6:0]      msel;             // Settings table index
  logic            skip_restart;     // Skip bring-up after core reset
  logic            after_restart;    // Sequence started by core reset
  sio_mcfg_s       act_cfg;          // Settings in force
  sio_mcfg_s       mcfg_tab [NUM_MOD]; // Stored module settings
  sio_mcfg_s       lcfg;             // Settings of module being loaded
  sio_mcfg_s       fcfg;             // Settings of module in socket
  logic [`SIO_INT_W-1:0] int_sts;    // Sticky event bits
  logic [`SIO_INT_W-1:0] int_msk;    // Event enable mask
  logic [`SIO_INT_W-1:0] int_ev;     // Events this cycle
  logic [`SIO_INT_W-1:0] next_int_sts;
  logic            acc;              // APB access completes
  logic            wr;               // Write completes
  logic            ctl_wr;           // Control register written
  logic            proceed;          // Proceed command
  logic            shut_cmd;         // Enter shutdown command
  logic            restart;          // Leave shutdown command
  logic            core_rst;         // Core reset command
  logic            fetch_done;       // Settings fetch finishes

  // Address match, used by every decode
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  // Known register address
  function automatic logic mapped(input logic [7:0] a);
    mapped = is_reg(a, `SIO_OFF_CTRL) | is_reg(a, `SIO_OFF_STATUS) |
             is_reg(a, `SIO_OFF_MSEL) | is_reg(a, `SIO_OFF_MCFG) |
             is_reg(a, `SIO_OFF_ISTS) | is_reg(a, `SIO_OFF_IMSK);
  endfunction : mapped

  // Bus access decode
  assign acc      = apb.psel & apb.penable & pready;
  assign wr       = acc & apb.pwrite;
  assign ctl_wr   = wr & is_reg(apb.paddr, `SIO_OFF_CTRL);
  assign proceed  = ctl_wr & apb.pwdata[`SIO_CTL_PROCEED];
  assign shut_cmd = ctl_wr & apb.pwdata[`SIO_CTL_SHUTDOWN];
  assign restart  = ctl_wr & apb.pwdata[`SIO_CTL_RESTART];
  assign core_rst = ctl_wr & apb.pwdata[`SIO_CTL_CORE_RST];

  // Settings lookups
  assign lcfg       = mcfg_tab[seq.load_id];
  assign fcfg       = mcfg_tab[cur_id];
  assign fetch_done = (state == SIO_FETCH) && (fetch_cnt == 3'h0);

  // Next state of the socket manager
  always_comb begin
    next_state = state;
    case (state)
      SIO_ACTIVE: begin
        // Removal may begin once shutdown is done
        if (seq.shutdown_done) begin
          next_state = SIO_LOADING;
        end
      end
      SIO_LOADING: begin
        // Pick first step after the load
        if (seq.load_done) begin
          if (lcfg.bringup_en) begin
            next_state = SIO_BRINGUP;
          end else if (lcfg.rst_en) begin
            next_state = SIO_RESET; // RULE10
          end else begin
            next_state = SIO_ACTIVE;
          end
        end
      end
      SIO_BRINGUP: begin
        // Wait without limit for software
        if (proceed) begin
          next_state = act_cfg.rst_en ? SIO_RESET : SIO_ACTIVE; // RULE13 RULE18
        end
      end
      SIO_RESET: begin
        // Pulse ends when the length is used up
        if (dur_cnt == 8'h00) begin
          next_state = SIO_ACTIVE;
        end
      end
      SIO_SHUTDOWN: begin
        if (restart) begin
          next_state = SIO_ACTIVE;
        end
      end
      SIO_FETCH: begin
        // After core reset, resume a full socket
        if (fetch_done) begin
          if (!full || skip_restart) begin
            next_state = SIO_ACTIVE;
          end else if (fcfg.bringup_en) begin
            next_state = SIO_BRINGUP;
          end else if (fcfg.rst_en) begin
            next_state = SIO_RESET; // RULE11
          end else begin
            next_state = SIO_ACTIVE;
          end
        end
      end
      default: begin
        next_state = SIO_ACTIVE;
      end
    endcase
    // Commands override the sequence
    if (state != SIO_SHUTDOWN && shut_cmd) begin
      next_state = SIO_SHUTDOWN;
    end else if (state != SIO_SHUTDOWN && core_rst) begin
      next_state = SIO_FETCH;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SIO_FETCH;
    end else begin
      state <= next_state;
    end
  end

  // Settings fetch delay and reset pulse length
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fetch_cnt <= `SIO_FETCH_CYC;
      dur_cnt   <= 8'h00;
    end else begin
      if (next_state == SIO_FETCH && state != SIO_FETCH) begin
        fetch_cnt <= `SIO_FETCH_CYC;
      end else if (state == SIO_FETCH && fetch_cnt != 3'h0) begin
        fetch_cnt <= fetch_cnt - 3'h1;
      end
      if (next_state == SIO_RESET && state != SIO_RESET) begin
        dur_cnt <= (state == SIO_LOADING) ? lcfg.dur :
                   (state == SIO_FETCH) ? fcfg.dur : act_cfg.dur; // RULE9
      end else if (state == SIO_RESET && dur_cnt != 8'h00) begin
        dur_cnt <= dur_cnt - 8'h01;
      end
    end
  end

  // Fill state, module identity and settings in force
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      full          <= POR_FULL;
      cur_id        <= POR_ID;
      act_cfg       <= POR_CFG; // RULE17
      after_restart <= 1'b1;
    end else begin
      if (state == SIO_ACTIVE && seq.shutdown_done) begin
        // Old module is gone once removal starts
        full <= 1'b0;
      end else if (state == SIO_LOADING && seq.load_done) begin
        full          <= 1'b1;
        cur_id        <= seq.load_id;
        act_cfg       <= lcfg;
        after_restart <= 1'b0;
      end
      if (fetch_done) begin
        act_cfg <= fcfg; // RULE17
      end
      if (core_rst && state != SIO_SHUTDOWN) begin
        after_restart <= 1'b1;
      end
    end
  end

  // Isolation output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      module_isolate <= !POR_FULL; // RULE1
    end else begin
      case (state)
        SIO_ACTIVE: begin
          if (seq.shutdown_done) begin
            module_isolate <= 1'b1; // RULE2 RULE3
          end else begin
            module_isolate <= !full; // RULE1 RULE4
          end
        end
        SIO_LOADING: begin
          // Release at once if no bring-up step
          module_isolate <= !(seq.load_done && !lcfg.bringup_en); // RULE3
        end
        SIO_BRINGUP: begin
          if (proceed || after_restart) begin
            module_isolate <= 1'b0; // RULE2 RULE6
          end
        end
        SIO_RESET: begin
          module_isolate <= 1'b0; // RULE4
        end
        SIO_SHUTDOWN: begin
          if (restart) begin
            module_isolate <= !full; // RULE8
          end else if (ctl_wr) begin
            module_isolate <= apb.pwdata[`SIO_CTL_MAN_ISO]; // RULE7
          end
        end
        SIO_FETCH: begin
          module_isolate <= module_isolate; // RULE5
        end
        default: begin
          module_isolate <= module_isolate;
        end
      endcase
    end
  end

  // Module reset output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      module_reset_out <= !POR_CFG.rst_hi; // RULE16
    end else begin
      case (state)
        SIO_LOADING: begin
          // New module's inactive level from the load edge on, while still isolated
          module_reset_out <= seq.load_done ? !lcfg.rst_hi : !act_cfg.rst_hi; // RULE9 RULE14
        end
        SIO_RESET: begin
          // Registered one edge after isolation drops
          module_reset_out <= act_cfg.rst_hi; // RULE10 RULE15 RULE19
        end
        SIO_SHUTDOWN: begin
          if (restart) begin
            module_reset_out <= !act_cfg.rst_hi;
          end else if (ctl_wr) begin
            module_reset_out <= apb.pwdata[`SIO_CTL_MAN_RST]; // RULE12
          end
        end
        SIO_FETCH: begin
          module_reset_out <= module_reset_out; // RULE14
        end
        default: begin
          module_reset_out <= !act_cfg.rst_hi; // RULE14
        end
      endcase
    end
  end

  // Bring-up request to software
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      software_bringup_request <= 1'b0;
    end else begin
      software_bringup_request <= (next_state == SIO_BRINGUP); // RULE18
    end
  end

  // Control and settings table registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      skip_restart <= 1'b0;
      msel         <= 7'h00;
      int_msk      <= '0;
      for (int i = 0; i < NUM_MOD; i++) begin
        mcfg_tab[i] <= POR_CFG;
      end
    end else if (wr) begin
      if (is_reg(apb.paddr, `SIO_OFF_CTRL)) begin
        skip_restart <= apb.pwdata[`SIO_CTL_SKIP]; // RULE11
      end
      if (is_reg(apb.paddr, `SIO_OFF_MSEL)) begin
        msel <= apb.pwdata[6:0];
      end
      if (is_reg(apb.paddr, `SIO_OFF_IMSK)) begin
        int_msk <= apb.pwdata[`SIO_INT_W-1:0];
      end
      if (is_reg(apb.paddr, `SIO_OFF_MCFG)) begin
        mcfg_tab[msel] <= {apb.pwdata[`SIO_MC_DUR_MSB:`SIO_MC_DUR_LSB],
                           apb.pwdata[`SIO_MC_BRINGUP],
                           apb.pwdata[`SIO_MC_RST_HI],
                           apb.pwdata[`SIO_MC_RST_EN]}; // RULE9
      end
    end
  end

  // Interrupt events, read clears, a new event wins
  always_comb begin
    int_ev = '0;
    int_ev[`SIO_INT_LOADED]  = (state == SIO_LOADING) && seq.load_done;
    int_ev[`SIO_INT_BRINGUP] = (next_state == SIO_BRINGUP) && (state != SIO_BRINGUP);
    int_ev[`SIO_INT_RSTDONE] = (state == SIO_RESET) && (next_state != SIO_RESET);
    next_int_sts = int_sts;
    if (acc && !apb.pwrite && is_reg(apb.paddr, `SIO_OFF_ISTS)) begin
      next_int_sts = '0;
    end
    next_int_sts = next_int_sts | int_ev;
  end

  // Interrupt status and line
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_sts <= '0;
      irq     <= 1'b0;
    end else begin
      int_sts <= next_int_sts;
      irq     <= |(next_int_sts & int_msk);
    end
  end

  // APB answer, prepared in the setup cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb.psel & !apb.penable;
      pslverr <= apb.psel & !apb.penable & !mapped(apb.paddr);
      prdata  <= 32'h0000_0000;
      if (apb.psel && !apb.penable && !apb.pwrite) begin
        if (is_reg(apb.paddr, `SIO_OFF_CTRL)) begin
          prdata[`SIO_CTL_SKIP] <= skip_restart;
        end
        if (is_reg(apb.paddr, `SIO_OFF_STATUS)) begin
          prdata[`SIO_ST_STATE_MSB:0]           <= state;
          prdata[`SIO_ST_FULL]                  <= full;
          prdata[`SIO_ST_ISO]                   <= module_isolate;
          prdata[`SIO_ST_RST]                   <= module_reset_out;
          prdata[`SIO_ST_REQ]                   <= software_bringup_request;
          prdata[`SIO_ST_ID_MSB:`SIO_ST_ID_LSB] <= cur_id;
        end
        if (is_reg(apb.paddr, `SIO_OFF_MSEL)) begin
          prdata[6:0] <= msel;
        end
        if (is_reg(apb.paddr, `SIO_OFF_MCFG)) begin
          prdata[`SIO_MC_DUR_MSB:`SIO_MC_DUR_LSB] <= mcfg_tab[msel].dur;
          prdata[`SIO_MC_BRINGUP] <= mcfg_tab[msel].bringup_en;
          prdata[`SIO_MC_RST_HI]  <= mcfg_tab[msel].rst_hi;
          prdata[`SIO_MC_RST_EN]  <= mcfg_tab[msel].rst_en;
        end
        if (is_reg(apb.paddr, `SIO_OFF_ISTS)) begin
          prdata[`SIO_INT_W-1:0] <= int_sts;
        end
        if (is_reg(apb.paddr, `SIO_OFF_IMSK)) begin
          prdata[`SIO_INT_W-1:0] <= int_msk;
        end
      end
    end
  end

endmodule : sio_socket_out

// File: rtl/sio_cfg.svh
`ifndef SIO_CFG_SVH
`define SIO_CFG_SVH
// Register byte offsets
`define SIO_OFF_CTRL     8'h00
`define SIO_OFF_STATUS   8'h04
`define SIO_OFF_MSEL     8'h08
`define SIO_OFF_MCFG     8'h0C
`define SIO_OFF_ISTS     8'h10
`define SIO_OFF_IMSK     8'h14
// Control register fields
`define SIO_CTL_PROCEED  0
`define SIO_CTL_SHUTDOWN 1
`define SIO_CTL_RESTART  2
`define SIO_CTL_CORE_RST 3
`define SIO_CTL_SKIP     4
`define SIO_CTL_MAN_ISO  8
`define SIO_CTL_MAN_RST  9
// Module settings fields
`define SIO_MC_RST_EN    0
`define SIO_MC_RST_HI    1
`define SIO_MC_BRINGUP   2
`define SIO_MC_DUR_LSB   8
`define SIO_MC_DUR_MSB   15
// Status register fields
`define SIO_ST_STATE_MSB 5
`define SIO_ST_FULL      8
`define SIO_ST_ISO       9
`define SIO_ST_RST       10
`define SIO_ST_REQ       11
`define SIO_ST_ID_LSB    16
`define SIO_ST_ID_MSB    22
// Interrupt bits
`define SIO_INT_LOADED   0
`define SIO_INT_BRINGUP  1
`define SIO_INT_RSTDONE  2
`define SIO_INT_W        3
// Settings fetch delay after reset, cycles
`define SIO_FETCH_CYC    3'h6
// Power-on module settings: reset on, active high, no bring-up, 1 cycle
`define SIO_POR_MCFG     11'h003
`endif

// File: rtl/sio_pkg.sv
package sio_pkg;
  // Socket manager states, one-hot
  typedef enum logic [5:0] {
    SIO_ACTIVE   = 6'h01,
    SIO_LOADING  = 6'h02,
    SIO_BRINGUP  = 6'h04,
    SIO_RESET    = 6'h08,
    SIO_SHUTDOWN = 6'h10,
    SIO_FETCH    = 6'h20
  } sio_state_e;
  // Stored settings of one loadable module
  typedef struct packed {
    logic [7:0] dur;        // Reset length minus one
    logic       bringup_en; // Software bring-up step on
    logic       rst_hi;     // Reset active high
    logic       rst_en;     // Reset after load on
  } sio_mcfg_s;
  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sio_apb_s;
  // Load sequence events from the controller
  typedef struct packed {
    logic       shutdown_done; // Shutdown steps done or skipped
    logic       load_done;     // Module image loaded
    logic [6:0] load_id;       // Module just loaded
  } sio_seq_s;
endpackage : sio_pkg

// File: dv/sio_socket_out_props.sv
`timescale 1ns/1ps
`include "sio_cfg.svh"
// Checks output sequencing seen at the block's ports
module sio_props
  import sio_pkg::*;
(
  input wire logic     clk,
  input wire logic     resetn,
  input wire sio_apb_s apb,
  input wire logic     pready,
  input wire sio_seq_s seq,
  input wire logic     module_isolate,
  input wire logic     module_reset_out,
  input wire logic     software_bringup_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic        wr;     // Control write takes effect
  logic        cmd;    // Control write with no shutdown, restart or core reset bit
  logic [31:0] d;      // Write data
  logic        in_sd;  // Shutdown state as told by commands
  logic        sd_iso; // Last written isolate value
  logic        sd_rst; // Last written reset value
  assign d = apb.pwdata;
  assign wr = apb.psel && apb.penable && pready && apb.pwrite && apb.paddr == `SIO_OFF_CTRL;
  assign cmd = wr && !d[1] && !d[2] && !d[3];
  // Follows shutdown entry and exit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_sd <= 1'b0;
      sd_iso <= 1'b0;
      sd_rst <= 1'b0;
    end else if (wr) begin
      in_sd <= !d[2] && !d[3] && (in_sd || d[1]);
      sd_iso <= d[8];
      sd_rst <= d[9];
    end
  end
  a_iso_rise_cause: assert property ($rose(module_isolate) |->
    $past(seq.shutdown_done) || $past(wr) || $past(wr, 2)) else $error("isolate rose alone");
  a_iso_fall_cause: assert property ($fell(module_isolate) |->
    $past(seq.load_done) || $past(wr) || $past(wr, 2)) else $error("isolate fell alone");
  a_bringup_rst_quiet: assert property (software_bringup_request &&
    $past(software_bringup_request) |-> $stable(module_reset_out)) else $error("reset in bring-up");
  a_req_iso_steady: assert property (software_bringup_request |->
    $stable(module_isolate)) else $error("isolate moved in bring-up");
  a_req_until_proceed: assert property ($fell(software_bringup_request) |->
    $past(wr) || $past(wr, 2)) else $error("request dropped alone");
  a_core_rst_hold: assert property (wr && d[3] |=>
    ($stable(module_isolate) && $stable(module_reset_out)) [*6]) else $error("core reset moved");
  a_sd_entry_hold: assert property (wr && d[1] && !d[2] && !d[3] && !in_sd |=>
    ($stable(module_isolate) && $stable(module_reset_out)) [*3]) else $error("entry moved");
  a_sd_manual: assert property (in_sd && cmd |-> ##2
    module_isolate == sd_iso && module_reset_out == sd_rst) else $error("manual value lost");
  c_bringup: cover property ($rose(software_bringup_request));
  c_manual: cover property (in_sd && cmd);
  c_release: cover property ($fell(module_isolate));
endmodule : sio_props
bind sio_socket_out sio_props u_props (.clk(clk), .resetn(resetn), .apb(apb), .pready(pready),
  .seq(seq), .module_isolate(module_isolate), .module_reset_out(module_reset_out),
  .software_bringup_request(software_bringup_request));

// File: dv/sio_far_end.sv
`timescale 1ns/1ps
// Decoupler and loaded module: counts reset cycles the module sees
module sio_far_end (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic module_isolate,
  input  wire logic module_reset_out,
  input  wire logic rst_hi,  // Active level of the loaded module
  input  wire logic clr,     // Clears the count
  output logic [9:0] act_cnt // Active cycles seen
);
  logic rst_dly; // Reset one cycle late so an edge is seen
  logic seen;    // Reset as the module sees it
  // Delays reset by a cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rst_dly <= !rst_hi;
    else rst_dly <= module_reset_out;
  end
  // Decoupler keeps reset off while isolated
  assign seen = module_isolate ? !rst_hi : rst_dly;
  // Counts active cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) act_cnt <= 10'h000;
    else if (clr) act_cnt <= 10'h000;
    else if (seen == rst_hi) act_cnt <= act_cnt + 10'h001;
  end
endmodule : sio_far_end

// File: dv/sio_socket_out_tb.sv
`timescale 1ns/1ps
`include "sio_cfg.svh"
module sio_socket_out_tb
  import sio_pkg::*;
;
  typedef struct { logic [6:0] id; logic [31:0] cfg; int n; } sio_row_s;
  logic        clk, resetn, pready, pslverr, iso, rst, req, irq, rst_hi, clr, erv;
  logic [31:0] prdata, rdv;
  logic [9:0]  act_cnt;
  sio_apb_s    apb;
  sio_seq_s    seq;
  int          n_errors, samples_checked;
  // Load rows: module, settings word, reset cycles seen
  sio_row_s rows [4] = '{'{7'h01, 32'h0003, 1}, '{7'h04, 32'hFF07, 256},
                         '{7'h03, 32'h0502, 0}, '{7'h02, 32'h0305, 4}};
  sio_socket_out dut (.clk(clk), .resetn(resetn), .apb(apb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .seq(seq), .module_isolate(iso), .module_reset_out(rst),
    .software_bringup_request(req), .irq(irq));
  sio_far_end far (.clk(clk), .resetn(resetn), .module_isolate(iso), .module_reset_out(rst),
    .rst_hi(rst_hi), .clr(clr), .act_cnt(act_cnt));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk1(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk1
  task chk32(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk32
  task summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // One APB transfer, held until pready is sampled high
  task apb_x(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int k;
    @(posedge clk);
    apb <= {1'b1, 1'b0, w, a, dv};
    @(posedge clk);
    apb.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // A missing answer counts as a mismatch
    if (k >= 50) n_errors++;
    rdv = prdata;
    erv = pslverr;
    apb <= '0;
  endtask : apb_x
  task rd(input logic [7:0] a, input logic [31:0] e, input string m);
    apb_x(1'b0, a, 32'h0);
    chk32(rdv, e, m);
  endtask : rd
  // Polls the state field
  task wait_st(input logic [5:0] s);
    int k;
    k = 0;
    do begin
      apb_x(1'b0, `SIO_OFF_STATUS, 32'h0);
      k++;
    end while (rdv[5:0] !== s && k < 400);
    chk32(rdv & 32'h3F, {26'h0, s}, "state");
  endtask : wait_st
  task pulse_sd;
    seq.shutdown_done <= 1'b1;
    @(posedge clk);
    seq.shutdown_done <= 1'b0;
    @(posedge clk);
  endtask : pulse_sd
  // Full removal and load of one module
  task load(input sio_row_s r);
    apb_x(1'b1, `SIO_OFF_MSEL, {25'h0, r.id});
    apb_x(1'b1, `SIO_OFF_MCFG, r.cfg);
    pulse_sd;
    chk1(iso, 1'b1, "isolate on removal");
    // Far end takes the new polarity only once isolated, so no stray count
    rst_hi <= r.cfg[1];
    clr <= 1'b1;
    seq <= {1'b0, 1'b1, r.id};
    @(posedge clk);
    clr <= 1'b0;
    seq.load_done <= 1'b0;
    if (r.cfg[2]) begin
      wait_st(SIO_BRINGUP);
      chk1(req, 1'b1, "bring-up request");
      chk1(iso, 1'b1, "isolated in bring-up");
      apb_x(1'b1, `SIO_OFF_CTRL, 32'h1);
    end
    wait_st(SIO_ACTIVE);
    // Let the delayed far-end count settle
    repeat (2) @(posedge clk);
    chk1(iso, 1'b0, "released");
    chk1(req, 1'b0, "request dropped");
    chk32({22'h0, act_cnt}, r.n, "reset cycles");
  endtask : load
  initial begin
    apb = '0;
    seq = '0;
    resetn = 1'b0;
    rst_hi = 1'b1;
    clr = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    chk1(iso, 1'b0, "power-on isolate");
    chk1(rst, 1'b0, "power-on reset");
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    chk1(rst, 1'b0, "build polarity");
    wait_st(SIO_ACTIVE);
    repeat (2) @(posedge clk);
    chk32({22'h0, act_cnt}, 32'h1, "power-on pulse");
    rd(8'h40, 32'h0, "unmapped data");
    chk1(erv, 1'b1, "unmapped error");
    rd(`SIO_OFF_IMSK, 32'h0, "mask reset");
    foreach (rows[i]) load(rows[i]);
    chk1(irq, 1'b0, "masked");
    apb_x(1'b1, `SIO_OFF_IMSK, 32'h7);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b1, "raised");
    rd(`SIO_OFF_ISTS, 32'h7, "events");
    repeat (2) @(posedge clk);
    chk1(irq, 1'b0, "cleared");
    clr <= 1'b1;
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h8);
    clr <= 1'b0;
    wait_st(SIO_BRINGUP);
    chk1(iso, 1'b0, "no isolate after core reset");
    chk1(rst, 1'b1, "reset waits for bring-up");
    chk1(req, 1'b1, "request after core reset");
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h1);
    wait_st(SIO_ACTIVE);
    repeat (2) @(posedge clk);
    chk32({22'h0, act_cnt}, 32'h4, "core reset pulse");
    clr <= 1'b1;
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h18);
    clr <= 1'b0;
    repeat (20) @(posedge clk);
    wait_st(SIO_ACTIVE);
    chk32({22'h0, act_cnt}, 32'h0, "skip gives no pulse");
    chk1(iso, 1'b0, "full kept");
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h2);
    chk1(iso, 1'b0, "entry holds");
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h300);
    repeat (2) @(posedge clk);
    chk1(iso, 1'b1, "manual isolate");
    chk1(rst, 1'b1, "manual reset");
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h104);
    repeat (2) @(posedge clk);
    chk1(iso, 1'b0, "restart full");
    chk1(rst, 1'b1, "restart inactive");
    pulse_sd;
    chk1(iso, 1'b1, "empty isolates");
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h2);
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk1(iso, 1'b0, "manual while empty");
    chk1(rst, 1'b0, "manual reset low");
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    chk1(iso, 1'b1, "restart empty");
    apb_x(1'b1, `SIO_OFF_CTRL, 32'h8);
    repeat (12) @(posedge clk);
    chk1(iso, 1'b1, "core reset empty");
    summarize;
  end
  // Cuts a hang short
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
endmodule : sio_socket_out_tb
